/* File: hdl/fmo_pkg.sv */
package fmo_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int WORD_W       = 16;
  localparam int MANT_IN_W    = 12;
  localparam int MANT_OUT_W   = 16;
  localparam int EXP_W        = 4;
  localparam int PAGE_W       = 3;
  localparam int PTR_W        = 6;
  localparam int DADDR_W      = 9;
  localparam int PROD_W       = 24;
  localparam int BOOTH_DIGITS = 6;
  localparam int TRUNC_BITS   = 6;

  // ==========================================================
  // Memory map
  // ==========================================================
  localparam int RAM_WORDS     = 200;
  localparam int RAM_PAGE_SIZE = 50;
  localparam int ROM_WORDS     = 128;
  localparam int ROM_PAGE_SIZE = 32;
  localparam int GR_COUNT      = 4;
  localparam int RAM_IDX_W     = 8;
  localparam int ROM_IDX_W     = 7;

  // ==========================================================
  // Exponent limits and saturation values
  // ==========================================================
  localparam logic signed [5:0] EXP_SUM_OVF   = 6'sd8;
  localparam logic signed [5:0] EXP_SUM_UNF   = -6'sd8;
  localparam logic [EXP_W-1:0]  EXP_MAX       = 4'h7;
  localparam logic [EXP_W-1:0]  EXP_MIN       = 4'h8;
  localparam logic [EXP_W-1:0]  EXP_FIXED     = 4'h0;
  localparam logic [15:0]       MANT_POS_MAX  = 16'h7FFF;
  localparam logic [15:0]       MANT_NEG_MAX  = 16'h8000;
  localparam logic [11:0]       MANT_IN_MINUS1 = 12'h800;
  localparam logic [15:0]       WORD_RESET    = 16'h0000;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    FMO_MODE_PTR_XY,
    FMO_MODE_PTR_XG,
    FMO_MODE_DIRECT
  } fmo_mode_type;

  typedef struct packed {
    fmo_mode_type             mode;
    logic [PAGE_W-1:0]        x_page;
    logic [PAGE_W-1:0]        y_page;
    logic [DADDR_W-1:0]       direct_addr;
  } fmo_instr_type;

  typedef struct packed {
    logic                     en;
    logic                     from_latch;
    logic                     to_working_register;
  } fmo_write_type;

  typedef struct packed {
    logic [MANT_OUT_W-1:0]    mant;
    logic [EXP_W-1:0]         exp;
  } fmo_float_type;

endpackage

/* File: hdl/fmo_float_multiplier_operand_memory.sv */
`timescale 1ns/1ps
// How it works
// RULE1: Multiply two 12-bit two's complement mantissas into a 16-bit product.
// RULE2: Add the two 4-bit exponents into a 4-bit result exponent.
// RULE3: Radix-4 Booth recoding gives six partial products, two bits apart.
// RULE4: Exponent sum +8, unnormalized: shift mantissa left one, exponent +7.
// RULE5: Exponent sum above +8, unnormalized: saturate mantissa keeping sign, exponent +7.
// RULE6: Exponent sum +8 or more, normalized: exponent +7, saturate mantissa keeping sign.
// RULE7: Exponent n of -8 or less: exponent -8, shift mantissa right by -8-n.
// RULE8: Minus one times minus one gives largest positive mantissa.
// RULE9: Drop partial product bits in the lowest six places; keep upper 16, no rounding.
// RULE10: Zero Y operand yields zero product; zero X need not.
// RULE11: Program multiplies in the same mode as the consuming add.
// RULE12: Program supplies normalized mantissas when exponent is above -8.
// RULE13: 200-word RAM, 128-word ROM, four working registers, two words per cycle.
// RULE14: RAM has four 50-word pages 0 to 3; two pages readable together.
// RULE15: Pointer mode: one RAM pointer offset, X page feeds X, Y page feeds Y.
// RULE16: RAM writes from accumulator or data latch go to pointer plus Y page.
// RULE17: Direct mode: 9-bit address drives the Y page and pointer lines.
// RULE18: ROM pages 4 to 7 by ROM pointer; one word may feed both buses.
// RULE19: Program uses one identical page when both page fields select ROM.
// RULE20: Sub-mode reads RAM or ROM to X while a working register feeds Y.
// RULE21: Direct mode multiplies the accumulator by the Y bus word.
// RULE22: Floating point stores keep only the upper 12 accumulator mantissa bits.
// RULE23: Two's complement mantissa and exponent, sign on top, exponent -8 to 7.
// RULE24: Product and exponent registered at cycle end for the adder next cycle.
module fmo_float_multiplier_operand_memory
  import fmo_pkg::*;
#(
  parameter logic [ROM_WORDS-1:0][WORD_W-1:0] ROM_INIT = '0
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire fmo_instr_type         instr_i,
  input  wire logic                  op_valid_i,
  input  wire logic                  float_mode_i,
  input  wire logic [PTR_W-1:0]      ram_ptr_i,
  input  wire logic [PTR_W-1:0]      rom_ptr_i,
  input  wire fmo_float_type         acc_i,
  input  wire logic [WORD_W-1:0]     data_holding_latch_i,
  input  wire fmo_write_type         write_i,
  output logic [WORD_W-1:0]          x_bus_o,
  output logic [WORD_W-1:0]          y_bus_o,
  output fmo_float_type              product_o,
  output logic                       product_valid_o
);

  // ==========================================================
  // Storage
  // ==========================================================
  logic [WORD_W-1:0]  ram_reg [0:RAM_WORDS-1];
  logic [WORD_W-1:0]  gr_reg  [0:GR_COUNT-1];

  // ==========================================================
  // Address formation
  // ==========================================================
  wire logic               is_direct;
  wire logic               is_xg;
  wire logic [PAGE_W-1:0]  eff_y_page;
  wire logic [PTR_W-1:0]   eff_ram_ptr;
  wire logic [PTR_W-1:0]   eff_rom_ptr;

  assign is_direct   = (instr_i.mode == FMO_MODE_DIRECT);
  assign is_xg       = (instr_i.mode == FMO_MODE_PTR_XG);
  assign eff_y_page  = is_direct ? instr_i.direct_addr[DADDR_W-1 -: PAGE_W]
                                 : instr_i.y_page;                        // see RULE17
  assign eff_ram_ptr = is_direct ? instr_i.direct_addr[PTR_W-1:0] : ram_ptr_i; // see RULE17
  assign eff_rom_ptr = is_direct ? instr_i.direct_addr[PTR_W-1:0] : rom_ptr_i;

  function automatic logic [RAM_IDX_W-1:0] ram_index(input logic [1:0] page,
                                                      input logic [PTR_W-1:0] off);
    logic [RAM_IDX_W-1:0] base;
    base = RAM_IDX_W'(page) * RAM_IDX_W'(RAM_PAGE_SIZE);
    return base + RAM_IDX_W'(off);
  endfunction

  function automatic logic [ROM_IDX_W-1:0] rom_index(input logic [1:0] page,
                                                      input logic [PTR_W-1:0] off);
    return {page, off[4:0]};
  endfunction

  wire logic                  x_is_rom;
  wire logic                  y_is_rom;
  wire logic                  x_off_ok;
  wire logic                  y_off_ok;
  wire logic [RAM_IDX_W-1:0]  x_ram_idx;
  wire logic [RAM_IDX_W-1:0]  y_ram_idx;
  wire logic [ROM_IDX_W-1:0]  x_rom_idx;
  wire logic [ROM_IDX_W-1:0]  y_rom_idx;

  assign x_is_rom  = instr_i.x_page[PAGE_W-1];                             // see RULE18
  assign y_is_rom  = eff_y_page[PAGE_W-1];                                 // see RULE18
  assign x_off_ok  = (eff_ram_ptr < PTR_W'(RAM_PAGE_SIZE));                // see RULE14
  assign y_off_ok  = x_off_ok;
  assign x_ram_idx = ram_index(instr_i.x_page[1:0], eff_ram_ptr);          // see RULE15
  assign y_ram_idx = ram_index(eff_y_page[1:0], eff_ram_ptr);              // see RULE15
  assign x_rom_idx = rom_index(instr_i.x_page[1:0], eff_rom_ptr);
  assign y_rom_idx = rom_index(eff_y_page[1:0], eff_rom_ptr);

  // ==========================================================
  // Bus read selection
  // ==========================================================
  wire logic [WORD_W-1:0]  x_ram_word;
  wire logic [WORD_W-1:0]  y_ram_word;
  wire logic [WORD_W-1:0]  x_mem_word;
  wire logic [WORD_W-1:0]  y_mem_word;
  wire logic [WORD_W-1:0]  x_bus;
  wire logic [WORD_W-1:0]  y_bus;

  assign x_ram_word = x_off_ok ? ram_reg[x_ram_idx] : WORD_RESET;          // see RULE14
  assign y_ram_word = y_off_ok ? ram_reg[y_ram_idx] : WORD_RESET;
  assign x_mem_word = x_is_rom ? ROM_INIT[x_rom_idx] : x_ram_word;         // see RULE18
  assign y_mem_word = y_is_rom ? ROM_INIT[y_rom_idx] : y_ram_word;         // see RULE18
  assign x_bus      = is_direct ? WORD_RESET : x_mem_word;                 // see RULE13
  assign y_bus      = is_xg ? gr_reg[instr_i.y_page[1:0]] : y_mem_word;    // see RULE20

  // ==========================================================
  // Multiplier operand selection
  // ==========================================================
  wire logic [MANT_IN_W-1:0]  x_mant;
  wire logic [MANT_IN_W-1:0]  y_mant;
  wire logic [EXP_W-1:0]      x_exp;
  wire logic [EXP_W-1:0]      y_exp;

  assign x_mant = is_direct ? acc_i.mant[MANT_OUT_W-1 -: MANT_IN_W]
                            : x_bus[WORD_W-1 -: MANT_IN_W];                // see RULE21
  assign x_exp  = is_direct ? acc_i.exp : x_bus[EXP_W-1:0];                // see RULE21
  assign y_mant = y_bus[WORD_W-1 -: MANT_IN_W];                            // see RULE1
  assign y_exp  = y_bus[EXP_W-1:0];                                        // see RULE23

  // ==========================================================
  // Booth mantissa multiplier
  // ==========================================================
  wire logic [MANT_IN_W:0]  y_ext;
  wire logic [PROD_W-1:0]   pp_trunc [0:BOOTH_DIGITS-1];

  assign y_ext = {y_mant, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < BOOTH_DIGITS; gi++) begin : g_booth
      wire logic               b_neg;
      wire logic               b_one;
      wire logic               b_two;
      wire logic [PROD_W-1:0]  x_sx;
      wire logic [PROD_W-1:0]  mag;
      wire logic [PROD_W-1:0]  pp;
      wire logic [PROD_W-1:0]  pp_shift;

      assign b_neg = y_ext[2*gi+2];                                        // see RULE3
      assign b_one = y_ext[2*gi+1] ^ y_ext[2*gi];                          // see RULE3
      assign b_two = (y_ext[2*gi+2] & ~y_ext[2*gi+1] & ~y_ext[2*gi])
                   | (~y_ext[2*gi+2] & y_ext[2*gi+1] & y_ext[2*gi]);       // see RULE3
      assign x_sx  = PROD_W'(signed'(x_mant));
      assign mag   = b_one ? x_sx : (b_two ? {x_sx[PROD_W-2:0], 1'b0} : '0);
      assign pp    = b_neg ? (~mag + PROD_W'(1)) : mag;
      assign pp_shift = pp << (2 * gi);                                    // see RULE3
      assign pp_trunc[gi] = {pp_shift[PROD_W-1:TRUNC_BITS], {TRUNC_BITS{1'b0}}}; // see RULE9
    end
  endgenerate

  logic [PROD_W-1:0] prod_sum;

  always_comb begin
    prod_sum = '0;
    for (int i = 0; i < BOOTH_DIGITS; i++) begin
      prod_sum = prod_sum + pp_trunc[i];                                   // see RULE10
    end
  end

  wire logic                   both_minus1;
  wire logic [MANT_OUT_W-1:0]  mant_raw;
  wire logic [MANT_OUT_W-1:0]  mant_fix;

  assign both_minus1 = (x_mant == MANT_IN_MINUS1) && (y_mant == MANT_IN_MINUS1);
  assign mant_raw    = prod_sum[PROD_W-2 -: MANT_OUT_W];                   // see RULE9
  assign mant_fix    = both_minus1 ? MANT_POS_MAX : mant_raw;              // see RULE8

  // ==========================================================
  // Exponent addition and protection
  // ==========================================================
  wire logic signed [5:0]      exp_sum;
  wire logic                   mant_norm;
  wire logic                   ovf_eq8;
  wire logic                   ovf_gt8;
  wire logic                   unf;
  wire logic [5:0]             unf_shift;
  wire logic [MANT_OUT_W-1:0]  mant_sat;
  wire logic [MANT_OUT_W-1:0]  mant_unf;

  assign exp_sum   = 6'(signed'(x_exp)) + 6'(signed'(y_exp));              // see RULE2
  assign mant_norm = mant_fix[MANT_OUT_W-1] ^ mant_fix[MANT_OUT_W-2];
  assign ovf_eq8   = (exp_sum == EXP_SUM_OVF);
  assign ovf_gt8   = (exp_sum > EXP_SUM_OVF);
  assign unf       = (exp_sum <= EXP_SUM_UNF);
  assign unf_shift = 6'(EXP_SUM_UNF - exp_sum);                            // see RULE7
  assign mant_sat  = mant_fix[MANT_OUT_W-1] ? MANT_NEG_MAX : MANT_POS_MAX;
  assign mant_unf  = MANT_OUT_W'($signed(mant_fix) >>> unf_shift);         // see RULE7

  fmo_float_type product_next;

  always_comb begin
    product_next.mant = mant_fix;
    product_next.exp  = EXP_FIXED;
    if (float_mode_i) begin
      product_next.exp = exp_sum[EXP_W-1:0];                               // see RULE2
      if (ovf_eq8 && !mant_norm) begin
        product_next.mant = {mant_fix[MANT_OUT_W-2:0], 1'b0};              // see RULE4
        product_next.exp  = EXP_MAX;                                       // see RULE4
      end else if (ovf_gt8 && !mant_norm) begin
        product_next.mant = mant_sat;                                      // see RULE5
        product_next.exp  = EXP_MAX;                                       // see RULE5
      end else if ((ovf_eq8 || ovf_gt8) && mant_norm) begin
        product_next.mant = mant_sat;                                      // see RULE6
        product_next.exp  = EXP_MAX;                                       // see RULE6
      end else if (unf) begin
        product_next.mant = mant_unf;                                      // see RULE7
        product_next.exp  = EXP_MIN;                                       // see RULE7
      end
    end
  end

  // ==========================================================
  // Write path
  // ==========================================================
  wire logic [WORD_W-1:0]     acc_word;
  wire logic [WORD_W-1:0]     write_word;
  wire logic                  ram_we;
  wire logic                  gr_we;
  wire logic [RAM_IDX_W-1:0]  write_idx;

  assign acc_word   = float_mode_i ? {acc_i.mant[MANT_OUT_W-1 -: MANT_IN_W], acc_i.exp}
                                   : acc_i.mant;                           // see RULE22
  assign write_word = write_i.from_latch ? data_holding_latch_i : acc_word; // see RULE16
  assign write_idx  = y_ram_idx;                                           // see RULE16
  assign ram_we     = write_i.en && !write_i.to_working_register
                   && !y_is_rom && y_off_ok;                               // see RULE16
  assign gr_we      = write_i.en && write_i.to_working_register;

  always_ff @(posedge clk_i) begin
    if (ram_we) begin
      ram_reg[write_idx] <= write_word;                                    // see RULE16
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < GR_COUNT; i++) begin
        gr_reg[i] <= WORD_RESET;
      end
    end else if (gr_we) begin
      gr_reg[eff_y_page[1:0]] <= write_word;
    end
  end

  // ==========================================================
  // Output registers
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      x_bus_o         <= WORD_RESET;
      y_bus_o         <= WORD_RESET;
      product_o       <= '0;
      product_valid_o <= 1'b0;
    end else begin
      x_bus_o         <= x_bus;
      y_bus_o         <= y_bus;
      product_o       <= product_next;                                     // see RULE24
      product_valid_o <= op_valid_i;                                       // see RULE24
    end
  end

endmodule

/* File: testbench/fmo_checker_sva.sv */
`timescale 1ns/1ps
module fmo_checker
  import fmo_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire fmo_instr_type     instr_i,
  input wire logic              op_valid_i,
  input wire logic              float_mode_i,
  input wire logic [PTR_W-1:0]  ram_ptr_i,
  input wire logic [WORD_W-1:0] x_bus_o,
  input wire logic [WORD_W-1:0] y_bus_o,
  input wire fmo_float_type     product_o,
  input wire logic              product_valid_o
);
  // ==========================================================
  // Operands of the product now on the outputs
  // ==========================================================
  fmo_instr_type     instr_reg;
  logic              flt_reg;
  logic [PTR_W-1:0]  ptr_reg;
  logic signed [5:0] sum_w;
  logic              fxy_w;
  logic              fix_w;
  logic              nrm_w;
  always_ff @(posedge clk_i) begin
    instr_reg <= instr_i;
    flt_reg   <= float_mode_i;
    ptr_reg   <= ram_ptr_i;
  end
  assign sum_w = $signed(x_bus_o[3:0]) + $signed(y_bus_o[3:0]);
  assign fxy_w = product_valid_o && flt_reg && instr_reg.mode == FMO_MODE_PTR_XY;
  assign fix_w = product_valid_o && !flt_reg && instr_reg.mode != FMO_MODE_DIRECT;
  assign nrm_w = (x_bus_o[15] ^ x_bus_o[14]) && (y_bus_o[15] ^ y_bus_o[14]);
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  valid_delay_a: assert property (1'b1 |=> product_valid_o == $past(op_valid_i))
    else $error("product valid not one cycle after request");
  exp_sum_a: assert property (fxy_w && sum_w > -8 && sum_w < 8 |-> product_o.exp == sum_w[3:0])
    else $error("exponent is not the sum");
  exp_ovf_a: assert property (fxy_w && sum_w >= 8 |-> product_o.exp == EXP_MAX)
    else $error("exponent overflow not held at plus seven");
  ovf_sat_a: assert property (fxy_w && sum_w > 8 && nrm_w |->
    product_o.mant == ((x_bus_o[15] ^ y_bus_o[15]) ? MANT_NEG_MAX : MANT_POS_MAX))
    else $error("mantissa not saturated with sign");
  exp_unf_a: assert property (fxy_w && sum_w <= -8 |-> product_o.exp == EXP_MIN)
    else $error("exponent underflow not held at minus eight");
  zero_y_a: assert property (fix_w && y_bus_o[15:4] == 12'h000 |-> product_o.mant == 16'h0000)
    else $error("zero Y operand gave nonzero product");
  minus_one_a: assert property (fix_w && x_bus_o[15:4] == MANT_IN_MINUS1 &&
    y_bus_o[15:4] == MANT_IN_MINUS1 |-> product_o.mant == MANT_POS_MAX)
    else $error("minus one squared not corrected");
  rom_share_a: assert property (instr_reg.mode == FMO_MODE_PTR_XY && instr_reg.x_page[2] &&
    instr_reg.x_page == instr_reg.y_page |-> x_bus_o == y_bus_o)
    else $error("one ROM word differs on the two buses");
  ram_gap_a: assert property (instr_reg.mode == FMO_MODE_PTR_XY && !instr_reg.x_page[2] &&
    ptr_reg >= 6'd50 |-> x_bus_o == 16'h0000)
    else $error("offset beyond page returned data");
  cover property (fxy_w && sum_w > 8);
  cover property (product_valid_o && instr_reg.mode == FMO_MODE_DIRECT);
  cover property (product_valid_o && instr_reg.mode == FMO_MODE_PTR_XG);
endmodule

/* File: testbench/fmo_float_multiplier_operand_memory_bench.sv */
`timescale 1ns/1ps
module fmo_float_multiplier_operand_memory_bench
  import fmo_pkg::*;
();
  logic              clk_i;
  logic              rst_n_i;
  fmo_instr_type     instr_i;
  logic              op_valid_i;
  logic              float_mode_i;
  logic [PTR_W-1:0]  ram_ptr_i;
  logic [PTR_W-1:0]  rom_ptr_i;
  fmo_float_type     acc_i;
  logic [WORD_W-1:0] data_holding_latch_i;
  fmo_write_type     write_i;
  logic [WORD_W-1:0] x_bus_o;
  logic [WORD_W-1:0] y_bus_o;
  fmo_float_type     product_o;
  logic              product_valid_o;
  int                fail_count;
  int                comparisons;
  int                cycles;
  // ==========================================================
  // Coefficient contents and device
  // ==========================================================
  function automatic logic [WORD_W-1:0] rw(input int i);
    return 16'h4001 | 16'(i << 4);
  endfunction
  function automatic logic [ROM_WORDS-1:0][WORD_W-1:0] mk_rom();
    for (int i = 0; i < ROM_WORDS; i++) mk_rom[i] = rw(i);
  endfunction
  fmo_float_multiplier_operand_memory #(.ROM_INIT(mk_rom())) u_fmo_float_multiplier_operand_memory (
    .clk_i, .rst_n_i, .instr_i, .op_valid_i, .float_mode_i, .ram_ptr_i, .rom_ptr_i, .acc_i,
    .data_holding_latch_i, .write_i, .x_bus_o, .y_bus_o, .product_o, .product_valid_o);
  // ==========================================================
  // Drivers and comparison
  // ==========================================================
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] pg, input logic [5:0] off, input logic [15:0] d,
                    input logic lt, input logic gr);
    instr_i = '{FMO_MODE_PTR_XY, 3'h0, pg, 9'h000};
    ram_ptr_i = off;
    data_holding_latch_i = d;
    op_valid_i = 1'b0;
    write_i = '{1'b1, lt, gr};
    @(negedge clk_i);
  endtask
  task automatic rd(input fmo_mode_type m, input logic [2:0] xp, input logic [2:0] yp,
                    input logic [5:0] off, input logic fl);
    instr_i = '{m, xp, yp, {yp, off}};
    ram_ptr_i = off;
    rom_ptr_i = off;
    float_mode_i = fl;
    op_valid_i = 1'b1;
    write_i = '0;
    @(negedge clk_i);
  endtask
  task automatic fm(input logic [11:0] x, input logic [11:0] y);
    logic signed [23:0] p;
    wr(3'h2, 6'd7, {x, 4'h0}, 1'b1, 1'b0);
    wr(3'h3, 6'd7, {y, 4'h0}, 1'b1, 1'b0);
    rd(FMO_MODE_PTR_XY, 3'h2, 3'h3, 6'd7, 1'b0);
    p = $signed(x) * $signed(y);
    chk(product_o, (x == 12'h800 && y == 12'h800) ? 20'h7FFF0 : {p[22:7], 4'h0});
  endtask
  task automatic ft(input logic [11:0] xm, input logic [3:0] xe, input logic [11:0] ym,
                    input logic [3:0] ye, input logic [19:0] e);
    wr(3'h0, 6'd5, {xm, xe}, 1'b1, 1'b0);
    wr(3'h1, 6'd5, {ym, ye}, 1'b1, 1'b0);
    rd(FMO_MODE_PTR_XY, 3'h0, 3'h1, 6'd5, 1'b1);
    chk(product_o, e);
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_mem();
    for (int p = 0; p < 4; p++) wr(3'(p), 6'd49, 16'hA500 | 16'(p), 1'b1, 1'b0);
    for (int p = 0; p < 4; p++) begin
      rd(FMO_MODE_PTR_XY, 3'(p), 3'((p + 1) % 4), 6'd49, 1'b0);
      chk({4'h0, x_bus_o}, {4'h0, 16'hA500 | 16'(p)});
      chk({4'h0, y_bus_o}, {4'h0, 16'hA500 | 16'((p + 1) % 4)});
    end
    rd(FMO_MODE_DIRECT, 3'h0, 3'h1, 6'd49, 1'b0);
    chk({4'h0, y_bus_o}, 20'h0A501);
    wr(3'h0, 6'd50, 16'hBEEF, 1'b1, 1'b0);
    wr(3'h5, 6'd3, 16'hBEEF, 1'b1, 1'b0);
    rd(FMO_MODE_PTR_XY, 3'h0, 3'h1, 6'd50, 1'b0);
    chk({4'h0, x_bus_o}, 20'h00000);
    rd(FMO_MODE_PTR_XY, 3'h5, 3'h5, 6'd3, 1'b0);
    chk({4'h0, x_bus_o}, {4'h0, rw(35)});
    chk({4'h0, y_bus_o}, {4'h0, rw(35)});
    rd(FMO_MODE_PTR_XY, 3'h4, 3'h7, 6'd31, 1'b0);
    chk({4'h0, x_bus_o}, {4'h0, rw(31)});
    chk({4'h0, y_bus_o}, {4'h0, rw(127)});
    wr(3'h2, 6'd0, 16'h5C3D, 1'b1, 1'b1);
    rd(FMO_MODE_PTR_XG, 3'h6, 3'h2, 6'd4, 1'b0);
    chk({4'h0, x_bus_o}, {4'h0, rw(68)});
    chk({4'h0, y_bus_o}, 20'h05C3D);
  endtask
  task automatic t_store();
    acc_i = '{16'h5A5F, 4'h3};
    float_mode_i = 1'b1;
    wr(3'h3, 6'd9, 16'h0000, 1'b0, 1'b0);
    rd(FMO_MODE_DIRECT, 3'h0, 3'h3, 6'd9, 1'b1);
    chk({4'h0, y_bus_o}, 20'h05A53);
    float_mode_i = 1'b0;
    wr(3'h3, 6'd10, 16'h0000, 1'b0, 1'b0);
    rd(FMO_MODE_DIRECT, 3'h0, 3'h3, 6'd10, 1'b0);
    chk({4'h0, y_bus_o}, 20'h05A5F);
    acc_i = '{16'h4000, 4'h1};
    wr(3'h1, 6'd5, 16'h4002, 1'b1, 1'b0);
    rd(FMO_MODE_DIRECT, 3'h0, 3'h1, 6'd5, 1'b1);
    chk(product_o, 20'h20003);
    chk({4'h0, x_bus_o}, 20'h00000);
  endtask
  task automatic t_mult();
    fm(12'h400, 12'h400);
    fm(12'hC00, 12'h7C0);
    fm(12'h7C0, 12'h123);
    fm(12'h840, 12'h9AB);
    fm(12'h400, 12'h000);
    fm(12'h800, 12'h800);
  endtask
  task automatic t_float();
    ft(12'h400, 4'h3, 12'h400, 4'h2, 20'h20005);
    ft(12'h400, 4'h4, 12'h400, 4'h4, 20'h40007);
    ft(12'h400, 4'h7, 12'h400, 4'h2, 20'h7FFF7);
    ft(12'hC00, 4'h7, 12'h400, 4'h2, 20'h80007);
    ft(12'h7C0, 4'h4, 12'h7C0, 4'h5, 20'h7FFF7);
    ft(12'h400, 4'hC, 12'h400, 4'hA, 20'h08008);
    ft(12'hC00, 4'hC, 12'h400, 4'hB, 20'hF0008);
  endtask
  // ==========================================================
  // Run control
  // ==========================================================
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    rst_n_i = 1'b0;
    instr_i = '0;
    op_valid_i = 1'b0;
    float_mode_i = 1'b0;
    ram_ptr_i = '0;
    rom_ptr_i = '0;
    acc_i = '0;
    data_holding_latch_i = '0;
    write_i = '0;
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    t_mem();
    t_store();
    t_mult();
    t_float();
    test_done();
  end
endmodule
bind fmo_float_multiplier_operand_memory fmo_checker u_fmo_checker (.clk_i, .rst_n_i, .instr_i,
  .op_valid_i, .float_mode_i, .ram_ptr_i, .x_bus_o, .y_bus_o, .product_o, .product_valid_o);
